// ==== rtl/cmsv_pkg.sv ====
// Purpose: constants and types of the message status view
// Assumes: 32-bit AHB-Lite data, word registers
// Notes:   offsets are byte addresses in a 4 KB window
// =====================================================
// package
package cmsv_pkg;
   localparam int NOBJ  = 32;
   localparam int HALF  = 16;
   localparam int OBJ_W = 5;
   localparam int ID_W  = 16;
   localparam int AW    = 12;
   localparam int EVT_W = 3;
   // =====================================================
   // register offsets
   localparam logic [AW-1:0] ADDR_ND_LO  = 12'h120;
   localparam logic [AW-1:0] ADDR_ND_HI  = 12'h124;
   localparam logic [AW-1:0] ADDR_IP_LO  = 12'h140;
   localparam logic [AW-1:0] ADDR_IP_HI  = 12'h144;
   localparam logic [AW-1:0] ADDR_MV_LO  = 12'h160;
   localparam logic [AW-1:0] ADDR_MV_HI  = 12'h164;
   localparam logic [AW-1:0] ADDR_EVT_ST = 12'h180;
   localparam logic [AW-1:0] ADDR_EVT_MK = 12'h184;
   localparam logic [AW-1:0] ADDR_IRQ_ID = 12'h188;
   // =====================================================
   // fields and reset values
   localparam int EVT_RX   = 0;
   localparam int EVT_TX   = 1;
   localparam int EVT_PEND = 2;
   localparam logic [NOBJ-1:0]  FLAGS_RST = 32'h0000_0000;
   localparam logic [NOBJ-1:0]  ONE_HOT0  = 32'h0000_0001;
   localparam logic [31:0]      WORD_ZERO = 32'h0000_0000;
   localparam logic [HALF-1:0]  HALF_ZERO = 16'h0000;
   localparam logic [ID_W-1:0]  ID_NONE   = 16'h0000;
   localparam logic [ID_W-1:0]  ID_MAX    = 16'h0020;
   localparam logic [EVT_W-1:0] EVT_RST   = 3'h0;
   localparam logic [1:0]       HRESP_OK  = 2'h0;
   // =====================================================
   // types
   typedef enum logic [2:0] {
      PH_IDLE  = 3'h1,
      PH_WRITE = 3'h2,
      PH_READ  = 3'h4
   } cmsv_phase_t;
endpackage

// ==== rtl/cmsv_flag_bank.sv ====
// Purpose: one bank of 32 per-object flags
// Assumes: set and clear vectors come from the message handler
// Notes:   hardware set beats any clear in the same cycle
`timescale 1ns/1ns
module cmsv_flag_bank (
   input  wire logic                       mclk,
   input  wire logic                       arst_n,
   input  wire logic [cmsv_pkg::NOBJ-1:0]  hw_set,
   input  wire logic [cmsv_pkg::NOBJ-1:0]  hw_clr,
   input  wire logic                       sw_we,
   input  wire logic [cmsv_pkg::OBJ_W-1:0] sw_obj,
   input  wire logic                       sw_val,
   output      logic [cmsv_pkg::NOBJ-1:0]  flags
);
   import cmsv_pkg::*;
   typedef struct packed {
      logic [NOBJ-1:0] flags;
   } cmsv_bank_t;
   cmsv_bank_t q;
   cmsv_bank_t next_q;
   // =====================================================
   // next state
   always_comb begin
      next_q = q;
      if (sw_we) begin
         next_q.flags[sw_obj] = sw_val;
      end
      next_q.flags = (next_q.flags & ~hw_clr) | hw_set;
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q.flags <= FLAGS_RST;
      end else begin
         q <= next_q;
      end
   end
   assign flags = q.flags;
endmodule // cmsv_flag_bank

// ==== rtl/cmsv_prio_enc.sv ====
// Purpose: lowest-numbered pending object to an id
// Assumes: bit 0 is object 1
// Notes:   pure logic; the caller registers the result
`timescale 1ns/1ns
module cmsv_prio_enc (
   input  wire logic [cmsv_pkg::NOBJ-1:0] pend,
   output      logic [cmsv_pkg::ID_W-1:0] id
);
   import cmsv_pkg::*;
   // =====================================================
   // scan downwards so the lowest object is kept last
   always_comb begin
      id = ID_NONE;
      for (int i = NOBJ - 1; i >= 0; i--) begin
         if (pend[i]) begin
            id = ID_W'(i + 1);
         end
      end
   end
endmodule // cmsv_prio_enc

// ==== rtl/cmsv_status_view.sv ====
// Purpose: packed new-data, pending and valid views over AHB-Lite
// Assumes: handler events are single-cycle pulses on mclk
// Notes:   zero wait states, response always OKAY
//
// Function
// - one readable new-data flag per each of 32 objects
// - handler updates new-data on stored frame or finished transmission
// - software changes new-data only through the interface set
// - new-data reads 1 after data written, 0 after software clear
// - objects 17-32 in bits 15:0 of the high word, objects 1-16 in bits 15:0 of the low word
// - one readable interrupt-pending flag per each of 32 objects
// - pending set by reception or transmission, or by interface set
// - a pending change shows in the reported source id only when it changes the lowest pending object
// - pending reads 1 when the object is an interrupt source
// - objects whose valid flag is 0 are ignored by the handler
// - all packed views read zero after reset
// - status views are read-only, writes change nothing
// - several pending objects: id names the lowest-numbered one
// - id reports object number 1 to 32 for object interrupts
`timescale 1ns/1ns
module cmsv_status_view (
   input  wire logic                       mclk,
   input  wire logic                       arst_n,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output      logic                       hreadyout,
   output      logic [1:0]                 hresp,
   output      logic [31:0]                hrdata,
   input  wire logic                       rx_store,
   input  wire logic [cmsv_pkg::OBJ_W-1:0] rx_obj,
   input  wire logic                       rx_irq_en,
   input  wire logic                       tx_done,
   input  wire logic [cmsv_pkg::OBJ_W-1:0] tx_obj,
   input  wire logic                       tx_irq_en,
   input  wire logic                       hif_xfer,
   input  wire logic [cmsv_pkg::OBJ_W-1:0] hif_obj,
   input  wire logic                       hif_wr_new_data,
   input  wire logic                       hif_new_data,
   input  wire logic                       hif_wr_irq,
   input  wire logic                       hif_irq_pending,
   input  wire logic                       hif_wr_valid,
   input  wire logic                       hif_valid,
   output      logic [cmsv_pkg::NOBJ-1:0]  new_data_flag,
   output      logic [cmsv_pkg::NOBJ-1:0]  object_irq_pending,
   output      logic [cmsv_pkg::NOBJ-1:0]  object_valid,
   output      logic [cmsv_pkg::ID_W-1:0]  irq_source_id,
   output      logic                       irq
);
   import cmsv_pkg::*;

   typedef struct packed {
      cmsv_phase_t      phase;
      logic [AW-1:0]    addr;
      logic [31:0]      rdata;
      logic [EVT_W-1:0] evt_status;
      logic [EVT_W-1:0] evt_mask;
      logic [ID_W-1:0]  id;
   } cmsv_state_t;

   cmsv_state_t      q;
   cmsv_state_t      next_q;
   logic             take;
   logic             rx_hit;
   logic             tx_hit;
   logic [NOBJ-1:0]  rx_vec;
   logic [NOBJ-1:0]  tx_vec;
   logic [NOBJ-1:0]  nd_set;
   logic [NOBJ-1:0]  nd_clr;
   logic [NOBJ-1:0]  ip_set;
   logic [ID_W-1:0]  id_comb;
   logic [EVT_W-1:0] evt_new;
   logic [31:0]      rd_mux;
   logic             hif_nd_we;
   logic             hif_ip_we;
   logic             hif_mv_we;

   // =====================================================
   // handler events, gated by the valid flags
   // an event on an unconfigured object is dropped here
   assign rx_hit = rx_store & object_valid[rx_obj];
   assign tx_hit = tx_done & object_valid[tx_obj];
   assign rx_vec = rx_hit ? (ONE_HOT0 << rx_obj) : FLAGS_RST;
   assign tx_vec = tx_hit ? (ONE_HOT0 << tx_obj) : FLAGS_RST;

   // stored frame marks new data, a sent frame consumes it
   assign nd_set = rx_vec;
   assign nd_clr = tx_vec & ~rx_vec;
   assign ip_set = (rx_irq_en ? rx_vec : FLAGS_RST)
                 | (tx_irq_en ? tx_vec : FLAGS_RST);

   // only the interface transfer writes single flags
   assign hif_nd_we = hif_xfer & hif_wr_new_data;
   assign hif_ip_we = hif_xfer & hif_wr_irq;
   assign hif_mv_we = hif_xfer & hif_wr_valid;

   // =====================================================
   // flag banks
   cmsv_flag_bank u_new_data (
      .mclk   (mclk),
      .arst_n (arst_n),
      .hw_set (nd_set),
      .hw_clr (nd_clr),
      .sw_we  (hif_nd_we),
      .sw_obj (hif_obj),
      .sw_val (hif_new_data),
      .flags  (new_data_flag)
   );

   cmsv_flag_bank u_irq_pending (
      .mclk   (mclk),
      .arst_n (arst_n),
      .hw_set (ip_set),
      .hw_clr (FLAGS_RST),
      .sw_we  (hif_ip_we),
      .sw_obj (hif_obj),
      .sw_val (hif_irq_pending),
      .flags  (object_irq_pending)
   );

   cmsv_flag_bank u_valid (
      .mclk   (mclk),
      .arst_n (arst_n),
      .hw_set (FLAGS_RST),
      .hw_clr (FLAGS_RST),
      .sw_we  (hif_mv_we),
      .sw_obj (hif_obj),
      .sw_val (hif_valid),
      .flags  (object_valid)
   );

   cmsv_prio_enc u_prio (
      .pend (object_irq_pending),
      .id   (id_comb)
   );

   // =====================================================
   // read mux, sampled in the address phase
   always_comb begin
      rd_mux = WORD_ZERO;
      if (haddr[AW-1:0] == ADDR_ND_LO) begin
         rd_mux = {HALF_ZERO, new_data_flag[HALF-1:0]};
      end else if (haddr[AW-1:0] == ADDR_ND_HI) begin
         rd_mux = {HALF_ZERO, new_data_flag[NOBJ-1:HALF]};
      end else if (haddr[AW-1:0] == ADDR_IP_LO) begin
         rd_mux = {HALF_ZERO, object_irq_pending[HALF-1:0]};
      end else if (haddr[AW-1:0] == ADDR_IP_HI) begin
         rd_mux = {HALF_ZERO, object_irq_pending[NOBJ-1:HALF]};
      end else if (haddr[AW-1:0] == ADDR_MV_LO) begin
         rd_mux = {HALF_ZERO, object_valid[HALF-1:0]};
      end else if (haddr[AW-1:0] == ADDR_MV_HI) begin
         rd_mux = {HALF_ZERO, object_valid[NOBJ-1:HALF]};
      end else if (haddr[AW-1:0] == ADDR_EVT_ST) begin
         rd_mux = {{(32-EVT_W){1'b0}}, q.evt_status};
      end else if (haddr[AW-1:0] == ADDR_EVT_MK) begin
         rd_mux = {{(32-EVT_W){1'b0}}, q.evt_mask};
      end else if (haddr[AW-1:0] == ADDR_IRQ_ID) begin
         rd_mux = {HALF_ZERO, q.id};
      end
   end

   // =====================================================
   // bus slave and event status
   assign take = hsel & hready & htrans[1];
   assign evt_new[EVT_RX]   = rx_hit;
   assign evt_new[EVT_TX]   = tx_hit;
   assign evt_new[EVT_PEND] = (q.id == ID_NONE) & (id_comb != ID_NONE);

   always_comb begin
      next_q = q;
      next_q.id = id_comb;
      next_q.phase = PH_IDLE;
      case (q.phase)
         PH_WRITE: begin
            // flag views have no bus write path, only the interface set and handler events write them
            if (q.addr == ADDR_EVT_ST) begin
               next_q.evt_status = q.evt_status & ~hwdata[EVT_W-1:0];
            end else if (q.addr == ADDR_EVT_MK) begin
               next_q.evt_mask = hwdata[EVT_W-1:0];
            end
         end
         default: begin
         end
      endcase
      // a new event outlasts a clear in the same cycle
      next_q.evt_status = next_q.evt_status | evt_new;
      if (take) begin
         next_q.addr = haddr[AW-1:0];
         if (hwrite) begin
            next_q.phase = PH_WRITE;
         end else begin
            next_q.phase = PH_READ;
            next_q.rdata = rd_mux;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q.phase      <= PH_IDLE;
         q.addr       <= '0;
         q.rdata      <= WORD_ZERO;
         q.evt_status <= EVT_RST;
         q.evt_mask   <= EVT_RST;
         q.id         <= ID_NONE;
      end else begin
         q <= next_q;
      end
   end

   assign hreadyout     = 1'b1;
   assign hresp         = HRESP_OK;
   assign hrdata        = q.rdata;
   assign irq_source_id = q.id;
   assign irq           = |(q.evt_status & q.evt_mask);

   // =====================================================
   // checks
   property p_rx_sets_nd;
      @(posedge mclk) disable iff (!arst_n)
      rx_hit |=> new_data_flag[$past(rx_obj)];
   endproperty
   a_rx_sets_nd: assert property (p_rx_sets_nd)
      else $error("stored frame did not set new data");

   property p_invalid_ignored;
      @(posedge mclk) disable iff (!arst_n)
      (rx_store && !object_valid[rx_obj] && !tx_done && !hif_xfer)
      |=> $stable(new_data_flag) && $stable(object_irq_pending);
   endproperty
   a_invalid_ignored: assert property (p_invalid_ignored)
      else $error("event on invalid object changed flags");

   property p_hif_nd;
      @(posedge mclk) disable iff (!arst_n)
      (hif_nd_we && !rx_hit && !tx_hit)
      |=> new_data_flag[$past(hif_obj)] == $past(hif_new_data);
   endproperty
   a_hif_nd: assert property (p_hif_nd)
      else $error("interface transfer did not write new data");

   property p_pend_set;
      @(posedge mclk) disable iff (!arst_n)
      (rx_hit && rx_irq_en) |=> object_irq_pending[$past(rx_obj)]
      ##1 irq_source_id != ID_NONE;
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("reception did not raise pending and id");

   property p_lowest;
      @(posedge mclk) disable iff (!arst_n)
      object_irq_pending[0] |=> irq_source_id == 16'h0001;
   endproperty
   a_lowest: assert property (p_lowest)
      else $error("object 1 pending but id differs");

   property p_id_range;
      @(posedge mclk) disable iff (!arst_n)
      (object_irq_pending == FLAGS_RST) |=> irq_source_id == ID_NONE;
   endproperty
   a_id_range: assert property (p_id_range)
      else $error("id nonzero with nothing pending");

   property p_id_max;
      @(posedge mclk) disable iff (!arst_n)
      irq_source_id <= ID_MAX;
   endproperty
   a_id_max: assert property (p_id_max)
      else $error("id beyond last object");

   property p_reset_zero;
      @(posedge mclk)
      !arst_n |-> (new_data_flag == FLAGS_RST)
         && (object_irq_pending == FLAGS_RST)
         && (object_valid == FLAGS_RST);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("views not zero in reset");

   property p_read_hi;
      @(posedge mclk) disable iff (!arst_n)
      (take && !hwrite && haddr[AW-1:0] == ADDR_ND_HI)
      |=> hrdata == {HALF_ZERO, $past(new_data_flag[NOBJ-1:HALF])};
   endproperty
   a_read_hi: assert property (p_read_hi)
      else $error("upper new data view misplaced");

   property p_ro_write;
      @(posedge mclk) disable iff (!arst_n)
      (q.phase == PH_WRITE && q.addr == ADDR_ND_LO
       && !rx_hit && !tx_hit && !hif_xfer)
      |=> $stable(new_data_flag);
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write changed read-only view");

   property p_read_quiet;
      @(posedge mclk) disable iff (!arst_n)
      (take && !hwrite && !rx_store && !tx_done && !hif_xfer)
      |=> $stable(object_irq_pending) && $stable(object_valid);
   endproperty
   a_read_quiet: assert property (p_read_quiet)
      else $error("read disturbed flags");

   property p_irq_out;
      @(posedge mclk) disable iff (!arst_n)
      (rx_hit && q.evt_mask[EVT_RX]
       && !(q.phase == PH_WRITE && q.addr == ADDR_EVT_MK))
      |=> irq;
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("unmasked event gave no interrupt");

   // a same-cycle reception on the object keeps new data set
   property p_tx_clears_nd;
      @(posedge mclk) disable iff (!arst_n)
      (tx_hit && !rx_hit && !hif_xfer) |=> !new_data_flag[$past(tx_obj)];
   endproperty
   a_tx_clears_nd: assert property (p_tx_clears_nd)
      else $error("finished transmission left new data set");

   property p_hif_ip;
      @(posedge mclk) disable iff (!arst_n)
      (hif_ip_we && !rx_hit && !tx_hit)
      |=> object_irq_pending[$past(hif_obj)] == $past(hif_irq_pending);
   endproperty
   a_hif_ip: assert property (p_hif_ip)
      else $error("interface transfer did not write pending");

   property p_pend_id;
      @(posedge mclk) disable iff (!arst_n)
      (object_irq_pending != FLAGS_RST) |=> irq_source_id != ID_NONE;
   endproperty
   a_pend_id: assert property (p_pend_id)
      else $error("pending object but id reads none");

   property p_valid_hold;
      @(posedge mclk) disable iff (!arst_n)
      !hif_mv_we |=> $stable(object_valid);
   endproperty
   a_valid_hold: assert property (p_valid_hold)
      else $error("valid flags changed without interface set");
endmodule // cmsv_status_view

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the message status view
// Assumes: zero-wait AHB-Lite slave, handler pulses one cycle
// Notes:   hready looped back from hreadyout, one slave only
`timescale 1ns/1ns
module tb_top;
   import cmsv_pkg::*;
   // ==================================================
   // signals
   logic             mclk, arst_n, hsel, hwrite, hreadyout, irq;
   logic [31:0]      haddr, hwdata, hrdata;
   logic [1:0]       htrans, hresp;
   logic [2:0]       hsize;
   logic             rx_store, rx_irq_en, tx_done, tx_irq_en, hif_xfer;
   logic             hif_wr_new_data, hif_new_data, hif_wr_irq;
   logic             hif_irq_pending, hif_wr_valid, hif_valid;
   logic [OBJ_W-1:0] rx_obj, tx_obj, hif_obj;
   logic [NOBJ-1:0]  new_data_flag, object_irq_pending, object_valid;
   logic [ID_W-1:0]  irq_source_id;
   int               failures, n_checks;
   logic [11:0]      va [7] = '{ADDR_ND_LO, ADDR_ND_HI, ADDR_IP_LO,
                               ADDR_IP_HI, ADDR_MV_LO, ADDR_MV_HI,
                               ADDR_IRQ_ID};
   logic [31:0]      ve [7] = '{32'h0000_0000, 32'h0000_8002,
                               32'h0000_0001, 32'h0000_0002,
                               32'h0000_0001, 32'h0000_8002,
                               32'h0000_0001};
   // ==================================================
   // design
   cmsv_status_view cmsv_status_view_inst (
      .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rx_store(rx_store), .rx_obj(rx_obj),
      .rx_irq_en(rx_irq_en), .tx_done(tx_done), .tx_obj(tx_obj),
      .tx_irq_en(tx_irq_en), .hif_xfer(hif_xfer), .hif_obj(hif_obj),
      .hif_wr_new_data(hif_wr_new_data), .hif_new_data(hif_new_data),
      .hif_wr_irq(hif_wr_irq), .hif_irq_pending(hif_irq_pending),
      .hif_wr_valid(hif_wr_valid), .hif_valid(hif_valid),
      .new_data_flag(new_data_flag),
      .object_irq_pending(object_irq_pending),
      .object_valid(object_valid), .irq_source_id(irq_source_id),
      .irq(irq));
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   // ==================================================
   // common tasks
   task automatic end_sim;
      if (failures == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // bounded wait: a stuck hreadyout ends the run
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         failures++;
         $display("BAD hreadyout exp 1 got %b", hreadyout);
         end_sim();
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk("hresp", {30'h0000_0000, HRESP_OK}, {30'h0000_0000, hresp});
   endtask
   task automatic rdchk(input string n, input logic [11:0] a,
                        input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, WORD_ZERO, d);
      chk(n, e, d);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   // one handler pulse, then settle so the id has caught up
   task automatic ev(input logic tx, input int o, input logic en);
      @(posedge mclk);
      rx_store <= ~tx;
      tx_done <= tx;
      rx_obj <= o[4:0];
      tx_obj <= o[4:0];
      rx_irq_en <= en;
      tx_irq_en <= en;
      @(posedge mclk);
      rx_store <= 1'b0;
      tx_done <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   // we/v bits: 0 new data, 1 pending, 2 valid
   task automatic hif(input int o, input logic [2:0] we,
                      input logic [2:0] v);
      @(posedge mclk);
      hif_xfer <= 1'b1;
      hif_obj <= o[4:0];
      {hif_wr_valid, hif_wr_irq, hif_wr_new_data} <= we;
      {hif_valid, hif_irq_pending, hif_new_data} <= v;
      @(posedge mclk);
      hif_xfer <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic chk_irq(input logic e);
      @(posedge mclk);
      chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
   endtask
   // ==================================================
   // scenarios
   task automatic t_reset;
      for (int i = 0; i < 7; i++) rdchk("view", va[i], WORD_ZERO);
      rdchk("evt_st", ADDR_EVT_ST, WORD_ZERO);
      chk("nd_all", WORD_ZERO, new_data_flag);
      chk("ip_all", WORD_ZERO, object_irq_pending);
      chk_irq(1'b0);
   endtask
   task automatic t_valid;
      hif(0, 3'b100, 3'b100);
      hif(17, 3'b100, 3'b100);
      hif(31, 3'b100, 3'b100);
      chk("valid", 32'h8002_0001, object_valid);
      rdchk("mv_lo", ADDR_MV_LO, 32'h0000_0001);
      rdchk("mv_hi", ADDR_MV_HI, 32'h0000_8002);
   endtask
   task automatic t_events;
      ev(1'b0, 5, 1'b1);
      chk("nd_inv", 32'h0000_0000, new_data_flag);
      chk("ip_inv", 32'h0000_0000, object_irq_pending);
      ev(1'b0, 31, 1'b0);
      ev(1'b0, 17, 1'b1);
      chk("id17", 32'h0000_0012, {16'h0000, irq_source_id});
      ev(1'b1, 0, 1'b1);
      chk("nd", 32'h8002_0000, new_data_flag);
      chk("ip", 32'h0002_0001, object_irq_pending);
      chk("id", 32'h0000_0001, {16'h0000, irq_source_id});
      rdchk("nd_hi", ADDR_ND_HI, 32'h0000_8002);
      rdchk("ip_lo", ADDR_IP_LO, 32'h0000_0001);
      rdchk("ip_hi", ADDR_IP_HI, 32'h0000_0002);
   endtask
   // writes must bounce off, and repeated reads must not disturb
   task automatic t_readonly;
      for (int i = 0; i < 7; i++) begin
         wr(va[i], 32'hFFFF_FFFF);
         rdchk("ro", va[i], ve[i]);
         rdchk("re", va[i], ve[i]);
      end
      wr(12'h1F0, 32'hFFFF_FFFF);
      rdchk("unmapped", 12'h1F0, WORD_ZERO);
   endtask
   task automatic t_irq;
      rdchk("evt_st", ADDR_EVT_ST, 32'h0000_0007);
      chk_irq(1'b0);
      wr(ADDR_EVT_MK, 32'h0000_0001);
      rdchk("evt_mk", ADDR_EVT_MK, 32'h0000_0001);
      chk_irq(1'b1);
      wr(ADDR_EVT_ST, 32'h0000_0001);
      rdchk("evt_w1c", ADDR_EVT_ST, 32'h0000_0006);
      chk_irq(1'b0);
      wr(ADDR_EVT_MK, 32'h0000_0007);
      chk_irq(1'b1);
      wr(ADDR_EVT_ST, 32'h0000_0006);
      rdchk("evt_clr", ADDR_EVT_ST, WORD_ZERO);
      chk_irq(1'b0);
      ev(1'b0, 31, 1'b0);
      chk_irq(1'b1);
      wr(ADDR_EVT_ST, 32'h0000_0001);
      chk_irq(1'b0);
   endtask
   task automatic t_hif;
      hif(0, 3'b010, 3'b000);
      chk("ip_clr", 32'h0002_0000, object_irq_pending);
      chk("id_mv", 32'h0000_0012, {16'h0000, irq_source_id});
      hif(17, 3'b010, 3'b000);
      chk("id_none", 32'h0000_0000, {16'h0000, irq_source_id});
      hif(31, 3'b001, 3'b000);
      chk("nd_clr", 32'h0002_0000, new_data_flag);
      hif(0, 3'b001, 3'b001);
      rdchk("nd_lo", ADDR_ND_LO, 32'h0000_0001);
   endtask
   // ==================================================
   // main sequence and watchdog
   initial begin
      failures = 0;
      n_checks = 0;
      arst_n = 1'b0;
      {hsel, hwrite, rx_store, rx_irq_en, tx_done, tx_irq_en} = 6'h00;
      {hif_xfer, hif_wr_new_data, hif_new_data, hif_wr_irq} = 4'h0;
      {hif_irq_pending, hif_wr_valid, hif_valid} = 3'h0;
      {rx_obj, tx_obj, hif_obj} = 15'h0000;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset();
      t_valid();
      t_events();
      t_readonly();
      t_irq();
      t_hif();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      $display("BAD watchdog exp done got hang");
      end_sim();
   end
endmodule // tb_top
